// [shared/chopper_pkg.sv]
package chopper_pkg;

  // ----------------------------------------------------------------
  // clock rates and chopper timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_KHZ = 25000;
  localparam int SYS_CLK_PERIOD_NS = 40;
  localparam int CHOP_CLK_KHZ = 1600;
  // integer divide: 25 MHz / 15 gives a 1.667 MHz chopper clock
  localparam int CHOP_DIV = SYS_CLK_KHZ / CHOP_CLK_KHZ;
  localparam int CHOP_PERIOD_CLKS = 16;
  localparam int FAST_START_CLK = 11;
  localparam int CNT_W = $clog2(CHOP_PERIOD_CLKS);
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CHOP_PERIOD_CLKS - 1);
  localparam logic [CNT_W-1:0] CNT_BEFORE_FAST = CNT_W'(FAST_START_CLK - 2);

  // spike blanking at the start of charge, rounded up to whole cycles
  localparam int BLANK_TIME_NS = 300;
  localparam int BLANK_CYCLES =
    (BLANK_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int BLANK_W = $clog2(BLANK_CYCLES + 1);

  // overcurrent masking, counted in chopper clock cycles
  localparam int OC_MASK_CLKS = 4;
  localparam int OC_TRIP_CLKS = OC_MASK_CLKS + 1;
  localparam int OC_W = 3;
  localparam logic [OC_W-1:0] OC_ZERO = 3'h0;
  localparam logic [OC_W-1:0] OC_TRIP_LAST = OC_W'(OC_TRIP_CLKS - 1);

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATE = 8'h04;
  localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] REG_IRQ_CLEAR = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_IRQ_ENABLE = 8'h10;

  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_INVERT_BIT = 1;
  localparam int CTRL_W = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;

  localparam int STATE_MODE_LSB = 0;
  localparam int STATE_COUNT_LSB = 4;
  localparam int STATE_RUN_BIT = 8;
  localparam int STATE_OC_BIT = 9;
  localparam int STATE_TH_BIT = 10;
  localparam int STATE_BLANK_BIT = 11;

  localparam int EV_PERIOD = 0;
  localparam int EV_LIMIT = 1;
  localparam int EV_OVERCURRENT = 2;
  localparam int EV_THERMAL = 3;
  localparam int EV_W = 4;
  localparam logic [EV_W-1:0] EV_NONE = 4'h0;

  typedef enum logic [1:0] {
    MODE_CHARGE = 2'b00,
    MODE_SLOW = 2'b01,
    MODE_FAST = 2'b10
  } chop_mode_t;

endpackage : chopper_pkg

// [logic/chopper_divider.sv]
`timescale 1ns/100ps

// one-cycle enable pulse at the chopper clock rate, restarted while idle
module chopper_divider #(
  parameter int DIV = 15
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // control
  input wire logic run,
  // chopper clock enable pulse
  output logic chopperOscClock
);

  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] DIV_LAST = W'(DIV - 1);
  localparam logic [W-1:0] DIV_ZERO = W'(0);

  logic [W-1:0] divCount_reg;

  // ----------------------------------------------------------------
  // divider counter
  // ----------------------------------------------------------------
  // counter and pulse held clear while stopped, so a period starts aligned
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      divCount_reg <= DIV_ZERO;
      chopperOscClock <= 1'b0;
    end else if (!run) begin
      divCount_reg <= DIV_ZERO;
      chopperOscClock <= 1'b0;
    end else if (divCount_reg == DIV_LAST) begin
      divCount_reg <= DIV_ZERO;
      chopperOscClock <= 1'b1;
    end else begin
      divCount_reg <= divCount_reg + W'(1);
      chopperOscClock <= 1'b0;
    end
  end

endmodule : chopper_divider

// [logic/stepper_mixed_decay_chopper.sv]
`timescale 1ns/100ps

module stepper_mixed_decay_chopper
  import chopper_pkg::*;
#(
  parameter int DIV = CHOP_DIV
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // wishbone slave
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  // host controls
  input wire logic standbyN,
  input wire logic phase,
  // sensing
  input wire logic currentLimitReached,
  input wire logic overcurrentSense,
  input wire logic thermalShutdown,
  // bridge gates
  output logic upperLeftSwitch,
  output logic upperRightSwitch,
  output logic lowerLeftSwitch,
  output logic lowerRightSwitch,
  // interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_reg;
  logic [EV_W-1:0] irqStatus_reg;
  logic [EV_W-1:0] irqStatus_next;
  logic [EV_W-1:0] irqEnable_reg;
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] clearBits;
  logic standbyN_reg;
  logic standbyRise;
  logic overcurrentShutdown_reg;
  logic thermalShutdown_reg;
  logic [OC_W-1:0] ocMask_reg;
  logic running;
  logic chopperOscClock;
  logic [CNT_W-1:0] chopCount_reg;
  chop_mode_t mode_reg;
  logic [BLANK_W-1:0] blankCount_reg;
  logic blanking;
  logic periodWrap;
  logic fastEntry;
  logic limitHit;
  logic ocTrip;
  logic forward;
  logic busReq;
  logic busDone;
  logic busWrite;
  logic [31:0] readData;

  // ----------------------------------------------------------------
  // run control and shutdown latches
  // ----------------------------------------------------------------
  // switches run only when enabled, out of standby and not tripped
  assign running = standbyN & ctrl_reg[CTRL_ENABLE_BIT]
                 & ~overcurrentShutdown_reg & ~thermalShutdown_reg;
  assign standbyRise = standbyN & ~standbyN_reg;

  // previous standby level for edge detection
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      standbyN_reg <= 1'b0;
    end else begin
      standbyN_reg <= standbyN;
    end
  end

  // overcurrent mask counter, counts chopper clocks while sensed
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ocMask_reg <= OC_ZERO;
    end else if (!running || !overcurrentSense) begin
      ocMask_reg <= OC_ZERO;
    end else if (chopperOscClock && ocMask_reg != OC_TRIP_LAST) begin
      ocMask_reg <= ocMask_reg + OC_W'(1);
    end
  end

  // trip after the mask has run out with overcurrent still present
  assign ocTrip = running & overcurrentSense & chopperOscClock
                & (ocMask_reg == OC_TRIP_LAST);

  // overcurrent latch, released only by a standby low-to-high edge
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      overcurrentShutdown_reg <= 1'b0;
    end else if (ocTrip) begin
      overcurrentShutdown_reg <= 1'b1;
    end else if (standbyRise) begin
      overcurrentShutdown_reg <= 1'b0;
    end
  end

  // thermal latch, same release; a live trip keeps it set
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      thermalShutdown_reg <= 1'b0;
    end else if (thermalShutdown) begin
      thermalShutdown_reg <= 1'b1;
    end else if (standbyRise) begin
      thermalShutdown_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // chopper clock and sequencer
  // ----------------------------------------------------------------
  chopper_divider #(
    .DIV(DIV)
  ) u_divider (
    .sys_clk(sys_clk),
    .reset(reset),
    .run(running),
    .chopperOscClock(chopperOscClock)
  );

  assign periodWrap = chopperOscClock & (chopCount_reg == CNT_LAST);
  assign fastEntry = chopperOscClock & (chopCount_reg == CNT_BEFORE_FAST);
  assign blanking = (blankCount_reg != BLANK_W'(0));
  // comparator only heard in charge once the blanking time is over
  assign limitHit = running & (mode_reg == MODE_CHARGE) & ~blanking
                  & currentLimitReached & ~periodWrap & ~fastEntry;

  // period counter: sixteen chopper clocks, wrapping to zero
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      chopCount_reg <= CNT_ZERO;
    end else if (!running) begin
      chopCount_reg <= CNT_ZERO;
    end else if (periodWrap) begin
      chopCount_reg <= CNT_ZERO;
    end else if (chopperOscClock) begin
      chopCount_reg <= chopCount_reg + CNT_W'(1);
    end
  end

  // decay mode: charge, then slow on limit, fast from the 11th clock
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mode_reg <= MODE_CHARGE;
    end else if (!running) begin
      mode_reg <= MODE_CHARGE;
    end else if (periodWrap) begin
      mode_reg <= MODE_CHARGE;
    end else if (fastEntry) begin
      mode_reg <= MODE_FAST;
    end else if (limitHit) begin
      mode_reg <= MODE_SLOW;
    end
  end

  // blanking timer reloaded whenever a charge interval begins
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      blankCount_reg <= BLANK_W'(BLANK_CYCLES);
    end else if (!running || periodWrap) begin
      blankCount_reg <= BLANK_W'(BLANK_CYCLES);
    end else if (blanking) begin
      blankCount_reg <= blankCount_reg - BLANK_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // bridge gate drive
  // ----------------------------------------------------------------
  assign forward = phase ^ ctrl_reg[CTRL_INVERT_BIT];

  // gates registered from mode and direction; all off when stopped
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      upperLeftSwitch <= 1'b0;
      upperRightSwitch <= 1'b0;
      lowerLeftSwitch <= 1'b0;
      lowerRightSwitch <= 1'b0;
    end else if (!running) begin
      upperLeftSwitch <= 1'b0;
      upperRightSwitch <= 1'b0;
      lowerLeftSwitch <= 1'b0;
      lowerRightSwitch <= 1'b0;
    end else begin
      case (mode_reg)
        MODE_CHARGE: begin
          upperLeftSwitch <= forward;
          upperRightSwitch <= ~forward;
          lowerLeftSwitch <= ~forward;
          lowerRightSwitch <= forward;
        end
        MODE_SLOW: begin
          upperLeftSwitch <= 1'b0;
          upperRightSwitch <= 1'b0;
          lowerLeftSwitch <= 1'b1;
          lowerRightSwitch <= 1'b1;
        end
        MODE_FAST: begin
          upperLeftSwitch <= ~forward;
          upperRightSwitch <= forward;
          lowerLeftSwitch <= forward;
          lowerRightSwitch <= ~forward;
        end
        default: begin
          upperLeftSwitch <= 1'b0;
          upperRightSwitch <= 1'b0;
          lowerLeftSwitch <= 1'b0;
          lowerRightSwitch <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  // request latched one cycle, committed at the edge that sees ack
  assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign busDone = wb_cyc_i & wb_stb_i & wb_ack_o;
  assign busWrite = busDone & wb_we_i & wb_sel_i[0];

  // acknowledge one cycle after the request, dropped the next
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= busReq;
    end
  end

  // read multiplexer; unmapped and write-only addresses read zero
  always_comb begin
    readData = 32'h0000_0000;
    case (wb_adr_i)
      REG_CTRL: readData[CTRL_W-1:0] = ctrl_reg;
      REG_STATE: begin
        readData[STATE_MODE_LSB +: 2] = mode_reg;
        readData[STATE_COUNT_LSB +: CNT_W] = chopCount_reg;
        readData[STATE_RUN_BIT] = running;
        readData[STATE_OC_BIT] = overcurrentShutdown_reg;
        readData[STATE_TH_BIT] = thermalShutdown_reg;
        readData[STATE_BLANK_BIT] = blanking;
      end
      REG_IRQ_STATUS: readData[EV_W-1:0] = irqStatus_reg;
      REG_IRQ_ENABLE: readData[EV_W-1:0] = irqEnable_reg;
      default: readData = 32'h0000_0000;
    endcase
  end

  // read data captured with the request so it stands with ack
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (busReq && !wb_we_i) begin
      wb_dat_o <= readData;
    end
  end

  // control and interrupt enable registers
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ctrl_reg <= CTRL_RESET;
      irqEnable_reg <= EV_NONE;
    end else if (busWrite) begin
      if (wb_adr_i == REG_CTRL) begin
        ctrl_reg <= wb_dat_i[CTRL_W-1:0];
      end
      if (wb_adr_i == REG_IRQ_ENABLE) begin
        irqEnable_reg <= wb_dat_i[EV_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  assign events[EV_PERIOD] = running & periodWrap;
  assign events[EV_LIMIT] = limitHit;
  assign events[EV_OVERCURRENT] = ocTrip;
  assign events[EV_THERMAL] = thermalShutdown & ~thermalShutdown_reg;
  assign clearBits = (busWrite && wb_adr_i == REG_IRQ_CLEAR) ?
                     wb_dat_i[EV_W-1:0] : EV_NONE;
  // a new event wins over a clear in the same cycle
  assign irqStatus_next = (irqStatus_reg & ~clearBits) | events;

  // sticky status bits
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      irqStatus_reg <= EV_NONE;
    end else begin
      irqStatus_reg <= irqStatus_next;
    end
  end

  // level interrupt, registered
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus_next & irqEnable_reg);
    end
  end

endmodule : stepper_mixed_decay_chopper

// [sim/chopper_properties.sv]
`timescale 1ns/100ps

// --------------------------------------------------------------
// bridge and bus checks
// --------------------------------------------------------------
module chopper_properties
  import chopper_pkg::*;
#(
  parameter int DIV = 2
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // wishbone
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // host and sensing
  input wire logic standbyN,
  input wire logic phase,
  input wire logic currentLimitReached,
  input wire logic overcurrentSense,
  input wire logic thermalShutdown,
  // bridge and interrupt
  input wire logic upperLeftSwitch,
  input wire logic upperRightSwitch,
  input wire logic lowerLeftSwitch,
  input wire logic lowerRightSwitch,
  input wire logic irq
);
  localparam int FAST_CYC = 6 * DIV;
  localparam int OC_MAX = 8 * DIV + 2;
  // longest charge: ten chopper clocks plus start-up and gate register
  localparam int CHARGE_MAX = (FAST_START_CLK - 1) * DIV + 2;
  // charge samples after which the comparator is heard again
  localparam int BLANK_RUN = BLANK_CYCLES - 1;
  logic invReg;
  logic fwdReg;
  logic [7:0] ocRun;
  logic [3:0] chargeRun;
  logic [3:0] sw;
  logic chargeSw, slowSw, fastSw, allOff;

  // bridge patterns for the current direction
  assign sw = {upperLeftSwitch, upperRightSwitch, lowerLeftSwitch,
    lowerRightSwitch};
  assign allOff = (sw == 4'h0);
  assign slowSw = (sw == 4'h3);
  assign chargeSw = (sw == (fwdReg ? 4'h9 : 4'h6));
  assign fastSw = (sw == (fwdReg ? 4'h6 : 4'h9));

  // direction as the bridge register last saw it
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      invReg <= 1'b0;
      fwdReg <= 1'b0;
    end else begin
      fwdReg <= phase ^ invReg;
      if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == REG_CTRL) begin
        invReg <= wb_dat_i[CTRL_INVERT_BIT];
      end
    end
  end

  // cycles of unbroken overcurrent while active
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ocRun <= 8'h00;
    end else if (!overcurrentSense || !standbyN || thermalShutdown) begin
      ocRun <= 8'h00;
    end else if (ocRun != 8'hFF) begin
      ocRun <= ocRun + 8'h01;
    end
  end

  // sampled cycles that the charge pattern has stood unbroken
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      chargeRun <= 4'h0;
    end else if (!chargeSw) begin
      chargeRun <= 4'h0;
    end else if (chargeRun != 4'hF) begin
      chargeRun <= chargeRun + 4'h1;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  AST_LEG_SAFE: assert property (!(sw[3] && sw[1]) &&
    !(sw[2] && sw[0])) else $error("leg shorted");
  AST_ACK_LAT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  AST_STANDBY_OFF: assert property (!standbyN |=> allOff)
    else $error("switch on in standby");
  AST_THERMAL_OFF: assert property (thermalShutdown |-> ##2 allOff)
    else $error("switch on after thermal trip");
  AST_BLANK: assert property ($rose(chargeSw) |=> !slowSw [*8])
    else $error("charge ended inside blanking");
  AST_LIMIT_SLOW: assert property (chargeRun >= BLANK_RUN && chargeSw
    && currentLimitReached |-> ##2 !chargeSw) else $error("limit ignored");
  AST_PERIOD: assert property ($rose(fastSw) |-> ##FAST_CYC
    (chargeSw || allOff)) else $error("fast decay length wrong");
  AST_CHARGE_MAX: assert property ($rose(chargeSw)
    |-> ##[1:CHARGE_MAX] !chargeSw) else $error("charge too long");
  AST_OC_MASK: assert property ($rose(overcurrentSense) && !allOff
    |=> !allOff [*8]) else $error("overcurrent not masked");
  AST_OC_MAX: assert property (ocRun == OC_MAX |-> allOff)
    else $error("overcurrent trip late");

  COV_SLOW: cover property ($rose(slowSw));
  COV_FAST: cover property ($rose(fastSw));
  COV_TRIP: cover property (overcurrentSense && $rose(allOff));
endmodule : chopper_properties

bind stepper_mixed_decay_chopper chopper_properties #(.DIV(DIV))
  chopper_properties_inst (.sys_clk, .reset, .wb_adr_i, .wb_dat_i,
  .wb_dat_o, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .standbyN, .phase, .currentLimitReached, .overcurrentSense,
  .thermalShutdown, .upperLeftSwitch, .upperRightSwitch,
  .lowerLeftSwitch, .lowerRightSwitch, .irq);

// [sim/winding_model.sv]
`timescale 1ns/100ps

// winding current rises while an upper switch feeds it, else decays
module winding_model #(
  parameter int LIM = 12
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // bridge gates
  input wire logic upperLeftSwitch,
  input wire logic upperRightSwitch,
  // comparator
  input wire logic limitEn,
  output logic currentLimitReached
);
  logic [5:0] lvlReg;

  // current level, saturating both ways
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      lvlReg <= 6'h00;
    end else if (upperLeftSwitch || upperRightSwitch) begin
      lvlReg <= (lvlReg == 6'h3F) ? lvlReg : lvlReg + 6'h01;
    end else if (lvlReg != 6'h00) begin
      lvlReg <= lvlReg - 6'h01;
    end
  end

  assign currentLimitReached = limitEn && (lvlReg >= LIM);
endmodule : winding_model

// [sim/stepper_mixed_decay_chopper_tb.sv]
`timescale 1ns/100ps

module stepper_mixed_decay_chopper_tb;
  import chopper_pkg::*;
  localparam int DIV = 2;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] rdat, datO;
  logic we = 1'b0, cyc = 1'b0, stb = 1'b0, ack, irq, limit;
  logic standbyN = 1'b0, phase = 1'b1, limitEn = 1'b1;
  logic ocSense = 1'b0, thermal = 1'b0;
  logic ul, ur, ll, lr;
  logic [3:0] sw;
  int errCount = 0;
  int checked = 0;

  always #20 sys_clk = ~sys_clk;
  assign sw = {ul, ur, ll, lr};

  stepper_mixed_decay_chopper #(.DIV(DIV)) stepper_mixed_decay_chopper_inst (
    .sys_clk, .reset, .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(datO),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_ack_o(ack), .standbyN, .phase, .currentLimitReached(limit),
    .overcurrentSense(ocSense), .thermalShutdown(thermal),
    .upperLeftSwitch(ul), .upperRightSwitch(ur), .lowerLeftSwitch(ll),
    .lowerRightSwitch(lr), .irq);
  winding_model winding_model_inst (.sys_clk, .reset, .upperLeftSwitch(ul),
    .upperRightSwitch(ur), .limitEn, .currentLimitReached(limit));

  task summarize;
    $display("checks %0d mismatches %0d", checked, errCount);
    if (errCount == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  task chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errCount++;
      $display("BAD %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk

  // one classic cycle; read data taken at the ack edge
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    {cyc, stb, we, sel, adr, wdat} <= {1'b1, 1'b1, w, 4'hF, a, d};
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rdat = datO;
    {cyc, stb, we, sel} <= 7'h00;
    if (n >= 50) begin
      errCount++;
      summarize();
    end
  endtask : wb

  task waitSw(input logic [3:0] p, output int n);
    n = 0;
    while (sw !== p) begin
      @(posedge sys_clk);
      n++;
      if (n > 3000) begin
        errCount++;
        summarize();
      end
    end
  endtask : waitSw

  task testRegs;
    wb(1'b0, REG_CTRL, 32'h0);
    chk("ctrlReset", rdat, 32'h0);
    wb(1'b1, REG_CTRL, 32'h2);
    wb(1'b0, REG_CTRL, 32'h0);
    chk("ctrlBack", rdat, 32'h2);
    wb(1'b1, REG_CTRL, 32'h0);
    wb(1'b0, REG_IRQ_CLEAR, 32'h0);
    chk("clearRead", rdat, 32'h0);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", rdat, 32'h0);
    $display("done regs");
  endtask : testRegs

  task testChop(input logic ph);
    int n;
    logic [3:0] chg, fst;
    chg = ph ? 4'h9 : 4'h6;
    fst = ph ? 4'h6 : 4'h9;
    {standbyN, phase, limitEn} <= {1'b1, ph, 1'b1};
    wb(1'b1, REG_CTRL, 32'h1);
    waitSw(chg, n);
    waitSw(4'h3, n);
    waitSw(fst, n);
    waitSw(chg, n);
    chk("fastLen", n, 6 * DIV);
    waitSw(4'h3, n);
    // comparator heard after the blank, gates follow one cycle later
    chk("blankLen", n, BLANK_CYCLES + 1);
    limitEn <= 1'b0;
    waitSw(fst, n);
    waitSw(chg, n);
    waitSw(fst, n);
    chk("chargeLen", n, 10 * DIV);
    wb(1'b1, REG_CTRL, 32'h0);
    $display("done chop %0d", ph);
  endtask : testChop

  task testStandby;
    int n;
    {phase, limitEn} <= 2'h3;
    // inverted direction: forward phase input gives the reverse pattern
    wb(1'b1, REG_CTRL, 32'h3);
    waitSw(4'h6, n);
    standbyN <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("standbyOff", sw, 32'h0);
    wb(1'b0, REG_STATE, 32'h0);
    chk("countClear", rdat[7:0], 32'h0);
    chk("runClear", rdat[STATE_RUN_BIT], 32'h0);
    wb(1'b1, REG_CTRL, 32'h1);
    standbyN <= 1'b1;
    waitSw(4'h9, n);
    $display("done standby");
  endtask : testStandby

  task testIrq;
    int n;
    wb(1'b1, REG_IRQ_ENABLE, 32'h1 << EV_PERIOD);
    for (n = 0; n < 200 && irq !== 1'b1; n++) @(posedge sys_clk);
    chk("irqUp", irq, 32'h1);
    if (irq !== 1'b1) summarize();
    wb(1'b0, REG_IRQ_STATUS, 32'h0);
    chk("periodEv", rdat[EV_PERIOD], 32'h1);
    chk("limitEv", rdat[EV_LIMIT], 32'h1);
    wb(1'b1, REG_IRQ_ENABLE, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk("irqMask", irq, 32'h0);
    standbyN <= 1'b0;
    wb(1'b1, REG_IRQ_CLEAR, 32'hF);
    wb(1'b0, REG_IRQ_STATUS, 32'h0);
    chk("statusClr", rdat, 32'h0);
    standbyN <= 1'b1;
    $display("done irq");
  endtask : testIrq

  task testTrip(input logic oc);
    int n;
    waitSw(4'h9, n);
    if (oc) ocSense <= 1'b1;
    else thermal <= 1'b1;
    if (!oc) @(posedge sys_clk);
    thermal <= 1'b0;
    waitSw(4'h0, n);
    if (oc) chk("ocMin", n >= 4 * DIV, 32'h1);
    chk("tripMax", n <= (oc ? 8 * DIV + 2 : 3), 32'h1);
    ocSense <= 1'b0;
    repeat (40) @(posedge sys_clk);
    chk("tripHold", sw, 32'h0);
    wb(1'b0, REG_STATE, 32'h0);
    chk("latch", rdat[oc ? STATE_OC_BIT : STATE_TH_BIT], 32'h1);
    wb(1'b0, REG_IRQ_STATUS, 32'h0);
    chk("tripEv", rdat[oc ? EV_OVERCURRENT : EV_THERMAL], 32'h1);
    standbyN <= 1'b0;
    @(posedge sys_clk);
    standbyN <= 1'b1;
    waitSw(4'h9, n);
    $display("done trip %0d", oc);
  endtask : testTrip

  initial begin
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    testRegs();
    testChop(1'b1);
    testChop(1'b0);
    testStandby();
    testIrq();
    testTrip(1'b1);
    testTrip(1'b0);
    summarize();
  end
endmodule : stepper_mixed_decay_chopper_tb
